// ### tb/sbc_assertions.sv
// concurrent checks on the pins between the basis chip and its host
`timescale 1ns/100ps
`default_nettype none
module sbc_assertions #(
  parameter int RST_CYC = 100
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic txd,
  input wire logic rxd,
  input wire logic reset_signal_n,
  input wire logic irq_n,
  input wire logic wd_fault_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] low_r;
  logic [7:0] hi_r;
  logic [3:0] rise_r;
  logic sclk_q;
  // length of the current reset-low stretch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) low_r <= '0;
    else low_r <= reset_signal_n ? '0 : low_r + 32'h1;
  end
  // cycles since the port was last selected, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) hi_r <= '0;
    else if (!cs_n) hi_r <= '0;
    else if (hi_r != 8'hff) hi_r <= hi_r + 8'h1;
  end
  // clock rises inside the current frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_q <= 1'b0;
      rise_r <= '0;
    end else begin
      sclk_q <= sclk;
      rise_r <= cs_n ? 4'h0 : rise_r + {3'h0, sclk & ~sclk_q};
    end
  end
  idle_after_rst_a: assert property ($fell(reset) |-> !reset_signal_n && irq_n)
    else $error("outputs not idle after reset");
  rst_hold_a: assert property ($rose(reset_signal_n) |-> low_r >= RST_CYC - 1)
    else $error("reset released too early");
  wd_reset_a: assert property ($fell(wd_fault_out_n) |-> ##[0:3] !reset_signal_n)
    else $error("watchdog fault without reset");
  wd_clear_a: assert property ($rose(wd_fault_out_n) |-> hi_r < 8'h28)
    else $error("watchdog fault cleared without service");
  irq_level_a: assert property ($fell(irq_n) |-> !irq_n [*8])
    else $error("interrupt shorter than a level");
  miso_quiet_a: assert property (cs_n [*8] |=> $stable(miso))
    else $error("data out moves while deselected");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  mosi_setup_a: assert property ($changed(mosi) |-> $rose(sclk) || $fell(cs_n))
    else $error("data in moves away from a clock rise");
  frame_len_a: assert property ($rose(cs_n) |-> rise_r == 4'h8)
    else $error("frame not eight bits");
  // main scenarios seen
  cover property ($fell(wd_fault_out_n));
  cover property ($rose(reset_signal_n));
  cover property ($fell(irq_n));
endmodule // sbc_assertions
`default_nettype wire

// ### tb/tb_top.sv
// end-to-end bench: host command port driving the basis chip core
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defines.svh"
module tb_top;
  localparam int RST_CYC = 100;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic vdd_low = 1'b0;
  logic temp_warn = 1'b0;
  logic temp_shut = 1'b0;
  logic ext_dom = 1'b0;
  logic [3:0] level_inputs = 4'ha;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_bit = 1'b1;
  logic bus_dominant;
  logic bus_drive_dom;
  logic vdd_reg_on;
  logic [1:0] can_mode;
  logic [31:0] rdata;
  logic rx_bit, chip_reset_n, chip_irq_n, chip_wd_fault_n;
  logic [3:0] r;
  int error_cnt = 0;
  int n_tests = 0;
  int k, n;
  sbc_if sif();
  // bus is dominant when either node forces it
  assign bus_dominant = bus_drive_dom | ext_dom;
  always #2.5 clk = ~clk;
  // short reset duration and watchdog base keep the run short
  sbc_device #(.RST_CYC(RST_CYC), .WD_BASE(8000)) i_sbc_device (.clk(clk), .reset(reset),
    .pins(sif.dev), .vdd_low(vdd_low), .temp_warn(temp_warn), .temp_shut(temp_shut),
    .bus_dominant(bus_dominant), .level_inputs(level_inputs),
    .bus_drive_dom(bus_drive_dom), .vdd_reg_on(vdd_reg_on), .can_mode(can_mode));
  sbc_host i_sbc_host (.clk(clk), .reset(reset), .pins(sif.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_bit(tx_bit), .rx_bit(rx_bit),
    .chip_reset_n(chip_reset_n), .chip_irq_n(chip_irq_n),
    .chip_wd_fault_n(chip_wd_fault_n));
  sbc_assertions #(.RST_CYC(RST_CYC)) i_sbc_assertions (.clk(clk), .reset(reset),
    .cs_n(sif.cs_n), .sclk(sif.sclk), .mosi(sif.mosi), .miso(sif.miso), .txd(sif.txd),
    .rxd(sif.rxd), .reset_signal_n(sif.reset_signal_n), .irq_n(sif.irq_n),
    .wd_fault_out_n(sif.wd_fault_out_n));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d of %0d compares", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    summarize();
  endtask
  // command port cycles, one strobe each, gap before the next
  task automatic wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_t(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // one serial message; busy covers the spacing between messages
  task automatic frame(input logic [3:0] a, input logic [3:0] d, output logic [3:0] q);
    logic [31:0] s;
    int j;
    j = 0;
    wr_t(`HA_CMD, {24'h0, a, d});
    do begin
      rd_t(`HA_STATUS, s);
      j++;
    end while (s[0] !== 1'b0 && j < 4000);
    if (j >= 4000) hang();
    rd_t(`HA_RXDATA, s);
    q = s[3:0];
  endtask
  // let the pass-through settle, then look: txd to rx_bit is ten flops deep
  task automatic settle;
    repeat (16) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 check(sif.reset_signal_n, 0);
    check(sif.wd_fault_out_n, 1);
    for (k = 0; k < 400 && sif.reset_signal_n !== 1'b1; k++) @(posedge clk);
    if (k == 400) hang();
    frame(`ADDR_WD, 4'h7, r);
    frame(`ADDR_MODE, 4'h0, r);
    frame(`ADDR_CAN, 4'h2, r);
    check(can_mode, 2'h2);
    tx_bit <= 1'b0;
    settle();
    check(bus_drive_dom, 1);
    check(rx_bit, 0);
    tx_bit <= 1'b1;
    settle();
    check(rx_bit, 1);
    frame(`ADDR_LEVEL, 4'h0, r);
    check(r, 4'ha);
    frame(`ADDR_WD, 4'h7, r);
    frame(`ADDR_MODE, 4'h2, r);
    // selecting the port wakes the core from stop with a short low pulse
    fork
      frame(`ADDR_LEVEL, 4'h0, r);
      begin
        for (k = 0; k < 900 && sif.irq_n !== 1'b0; k++) @(posedge clk);
        for (n = 0; n < 3000 && sif.irq_n === 1'b0; n++) @(posedge clk);
      end
    join
    check(n > 1990 && n < 2010, 1);
    frame(`ADDR_MODE, 4'h1, r);
    tx_bit <= 1'b0;
    ext_dom <= 1'b1;
    settle();
    check(bus_drive_dom, 0);
    check(rx_bit, 0);
    tx_bit <= 1'b1;
    ext_dom <= 1'b0;
    temp_warn <= 1'b1;
    temp_shut <= 1'b1;
    settle();
    check(chip_irq_n, 1);
    check(vdd_reg_on, 0);
    frame(`ADDR_IRQ_EN, 4'h1, r);
    check(sif.irq_n, 0);
    temp_warn <= 1'b0;
    temp_shut <= 1'b0;
    repeat (50) @(posedge clk);
    #1 check(sif.irq_n, 0);
    check(vdd_reg_on, 1);
    frame(`ADDR_IRQ_CLR, 4'h1, r);
    check(sif.irq_n, 1);
    frame(`ADDR_WD, 4'h9, r);
    frame(`ADDR_WD, 4'h9, r);
    check(sif.wd_fault_out_n, 0);
    frame(`ADDR_WD, 4'h0, r);
    check(sif.wd_fault_out_n, 1);
    for (k = 0; k < 9000 && sif.wd_fault_out_n !== 1'b0; k++) @(posedge clk);
    if (k == 9000) hang();
    repeat (4) @(posedge clk);
    #1 check(sif.reset_signal_n, 0);
    for (k = 0; k < 400 && sif.reset_signal_n !== 1'b1; k++) @(posedge clk);
    if (k == 400) hang();
    vdd_low <= 1'b1;
    settle();
    check(chip_reset_n, 0);
    vdd_low <= 1'b0;
    for (k = 0; k < 400 && sif.reset_signal_n !== 1'b1; k++) @(posedge clk);
    check(k > RST_CYC - 8 && k < 400, 1);
    summarize();
  end
endmodule // tb_top
`default_nettype wire

// ### verilog/sbc_defines.svh
// timing counts, register addresses and field positions for the basis chip core
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
// core clock 200 MHz, period in ps
`define CLK_PERIOD_PS 5000
// wake pulse on interrupt line, us
`define WAKE_PULSE_US 10
`define WAKE_PULSE_CYC ((`WAKE_PULSE_US * 1000000) / `CLK_PERIOD_PS)
// reset duration, ms
`define RST_DUR_MS 15
// divide first in ns so the product stays inside 32 bits
`define RST_DUR_CYC ((`RST_DUR_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
// wake-up filter time (least), us
`define WUF_US 8
`define WUF_CYC ((`WUF_US * 1000000) / `CLK_PERIOD_PS)
// spacing between messages to one register, us
`define MSG_GAP_US 25
`define MSG_GAP_CYC ((`MSG_GAP_US * 1000000) / `CLK_PERIOD_PS)
// default watchdog base period and wake timer, cycles
`define WD_BASE_CYC 20000
`define WAKE_TMR_CYC 200000
// host-side spi clock half period, core cycles (80 ns)
`define SCLK_HALF_CYC 16
// serial frame: 4 bit address, 4 bit data
`define ADDR_MODE 4'h0
`define ADDR_WD 4'h1
`define ADDR_IRQ_EN 4'h2
`define ADDR_WAKE_EN 4'h3
`define ADDR_CAN 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_LEVEL 4'h6
`define ADDR_IRQ_CLR 4'h7
// status bits
`define ST_TEMP_WARN 0
`define ST_WAKE 1
`define ST_WD_FAIL 2
`define ST_TEMP_SHUT 3
// host command port addresses
`define HA_CMD 4'h0
`define HA_STATUS 4'h1
`define HA_RXDATA 4'h2
`endif

// ### verilog/sbc_device.sv
// basis chip digital core: spi slave, modes, watchdog, reset and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defines.svh"
// Function
// - sample mosi on sclk falling edge
// - shift miso after sclk rising edge
// - serial port live only while cs low
// - txd low forces bus dominant in normal mode with can active
// - rxd low while bus dominant
// - reset output low during reset mode
// - supply under-voltage pulls reset low
// - interrupt low only for enabled sources or the stop mode wake pulse
// - interrupt holds low until source cleared
// - stop mode wake: 10 us low pulse
// - watchdog fault output flags bad service
// - window or timeout watchdog, host selects
// - watchdog failure drives fault and reset
// - level inputs readable over serial port
// - level inputs wake sleep and stop
// - wake on bus, levels or timer
// - host writes select four operating modes
// - can mode set only by serial bits
// - temperature warning flag and shutdown
// - reset held 15 ms after supply valid
// - host spaces same-register messages 25 us
// - reset on supply, timeout or early trigger
module sbc_device #(
  parameter int RST_CYC = `RST_DUR_CYC,
  parameter int WD_BASE = `WD_BASE_CYC,
  parameter int WAKE_TMR = `WAKE_TMR_CYC
) (
  // core clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins toward the microcontroller
  sbc_if.dev pins,
  // analog side
  input wire logic vdd_low,
  input wire logic temp_warn,
  input wire logic temp_shut,
  input wire logic bus_dominant,
  input wire logic [3:0] level_inputs,
  output logic bus_drive_dom,
  output logic vdd_reg_on,
  output logic [1:0] can_mode
);
  logic cs_s, sclk_s, mosi_s, txd_s, vlow_s, tw_s, ts_s, bdom_s;
  logic [3:0] lvl_s;
  // init at idle pin levels: no false select, edge or flag right after reset
  sync2 #(.W(12), .INIT(12'h900)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({pins.cs_n, pins.sclk, pins.mosi, pins.txd, level_inputs,
        vdd_low, temp_warn, temp_shut, bus_dominant}),
    .q({cs_s, sclk_s, mosi_s, txd_s, lvl_s, vlow_s, tw_s, ts_s, bdom_s})
  );

  typedef enum logic [2:0] {ST_RESET, ST_NREQ, ST_NORMAL, ST_STANDBY, ST_STOP,
    ST_SLEEP} dev_state_t;
  dev_state_t state_r;
  logic sclk_d_r, cs_d_r;
  logic [7:0] rx_sh_r, tx_sh_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] mode_req_r;
  logic mode_wr_r, wd_trig_r;
  logic [3:0] wd_cfg_r, irq_en_r, wake_en_r, status_r, clr_mask_r;
  logic [1:0] can_cfg_r;
  logic [31:0] rst_cnt_r, wd_cnt_r, wake_tmr_r, pulse_cnt_r;
  logic [15:0] filt_cnt_r;
  logic [3:0] lvl_ref_r;
  logic wake_ev, wd_fail, fall, rise, sel, irq_lvl;

  assign sel = ~cs_s;
  assign fall = sel & sclk_d_r & ~sclk_s;
  assign rise = sel & ~sclk_d_r & sclk_s;

  // read data for an address
  function automatic logic [3:0] rd_mux(input logic [3:0] a);
    case (a)
      `ADDR_MODE: rd_mux = {1'b0, state_r == ST_RESET, mode_req_r};
      `ADDR_WD: rd_mux = wd_cfg_r;
      `ADDR_IRQ_EN: rd_mux = irq_en_r;
      `ADDR_WAKE_EN: rd_mux = wake_en_r;
      `ADDR_CAN: rd_mux = {2'b00, can_cfg_r};
      `ADDR_STATUS: rd_mux = status_r;
      `ADDR_LEVEL: rd_mux = lvl_s;
      default: rd_mux = 4'h0;
    endcase
  endfunction

  // serial shifter: frame is addr[3:0] then data[3:0], msb first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      bit_cnt_r <= 4'h0;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_s;
      if (!sel) begin
        bit_cnt_r <= 4'h0;
        tx_sh_r <= 8'h00;
      end else if (fall) begin
        rx_sh_r <= {rx_sh_r[6:0], mosi_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
        // once address is known, preload read data behind it
        if (bit_cnt_r == 4'h3) begin
          tx_sh_r <= {rd_mux({rx_sh_r[2:0], mosi_s}), 4'h0};
        end
      end else if (rise && bit_cnt_r != 4'h0 && bit_cnt_r != 4'h4) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  // register writes complete on the eighth falling edge
  logic wr_now;
  assign wr_now = fall && bit_cnt_r == 4'h7 && state_r != ST_RESET;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_req_r <= 2'b01;
      mode_wr_r <= 1'b0;
      wd_trig_r <= 1'b0;
      wd_cfg_r <= 4'h0;
      irq_en_r <= 4'h0;
      wake_en_r <= 4'h0;
      can_cfg_r <= 2'b00;
      clr_mask_r <= 4'h0;
    end else begin
      mode_wr_r <= wr_now && rx_sh_r[6:3] == `ADDR_MODE;
      wd_trig_r <= wr_now && rx_sh_r[6:3] == `ADDR_WD;
      clr_mask_r <= 4'h0;
      if (wr_now) begin
        case (rx_sh_r[6:3])
          `ADDR_MODE: mode_req_r <= {rx_sh_r[0], mosi_s};
          `ADDR_WD: wd_cfg_r <= {rx_sh_r[2:0], mosi_s};
          `ADDR_IRQ_EN: irq_en_r <= {rx_sh_r[2:0], mosi_s};
          `ADDR_WAKE_EN: wake_en_r <= {rx_sh_r[2:0], mosi_s};
          `ADDR_CAN: can_cfg_r <= {rx_sh_r[0], mosi_s};
          `ADDR_IRQ_CLR: clr_mask_r <= {rx_sh_r[2:0], mosi_s};
          default: ;
        endcase
      end
    end
  end

  // watchdog: cfg[3] window mode, cfg[2:0] scales timeout; first half closed
  logic [31:0] wd_limit;
  assign wd_limit = WD_BASE * (32'(wd_cfg_r[2:0]) + 32'h1);
  logic wd_active;
  assign wd_active = state_r == ST_NORMAL || state_r == ST_STANDBY || state_r == ST_NREQ;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wd_cnt_r <= 32'h0;
    end else if (!wd_active || wd_trig_r) begin
      wd_cnt_r <= 32'h0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 32'h1;
    end
  end
  assign wd_fail = wd_active && ((wd_cnt_r >= wd_limit) ||
    (wd_trig_r && wd_cfg_r[3] && wd_cnt_r < (wd_limit >> 1)));

  // wake filtering, timer and can activity
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvl_ref_r <= 4'h0;
      filt_cnt_r <= 16'h0;
      wake_tmr_r <= 32'h0;
    end else begin
      if (state_r == ST_STOP || state_r == ST_SLEEP) begin
        wake_tmr_r <= wake_tmr_r + 32'h1;
        if (((lvl_s ^ lvl_ref_r) & wake_en_r) != 4'h0) begin
          filt_cnt_r <= filt_cnt_r + 16'h1;
        end else begin
          filt_cnt_r <= 16'h0;
        end
      end else begin
        lvl_ref_r <= lvl_s;
        filt_cnt_r <= 16'h0;
        wake_tmr_r <= 32'h0;
      end
    end
  end
  assign wake_ev = (filt_cnt_r >= 16'(`WUF_CYC)) || bdom_s ||
    (wake_tmr_r >= 32'(WAKE_TMR)) ||
    (state_r == ST_STOP && cs_d_r && !cs_s);
  // select edge only: the frame that ordered stop still holds cs low on entry

  // operating mode machine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_RESET;
      rst_cnt_r <= 32'h0;
    end else if (vlow_s || wd_fail) begin
      state_r <= ST_RESET;
      rst_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        ST_RESET: begin
          rst_cnt_r <= rst_cnt_r + 32'h1;
          if (rst_cnt_r >= 32'(RST_CYC) - 32'h1) state_r <= ST_NREQ;
        end
        ST_NREQ, ST_NORMAL, ST_STANDBY: begin
          if (mode_wr_r) begin
            case (sbc_pkg::op_mode_t'(mode_req_r))
              sbc_pkg::MODE_NORMAL: state_r <= ST_NORMAL;
              sbc_pkg::MODE_STANDBY: state_r <= ST_STANDBY;
              sbc_pkg::MODE_STOP: state_r <= ST_STOP;
              default: state_r <= ST_SLEEP;
            endcase
          end
        end
        ST_STOP: if (wake_ev) state_r <= ST_NREQ;
        ST_SLEEP: if (wake_ev) begin
          state_r <= ST_RESET;
          rst_cnt_r <= 32'h0;
        end
        default: state_r <= ST_RESET;
      endcase
    end
  end
  // sticky status: set wins over clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r <= 4'h0;
    end else begin
      status_r <= (status_r & ~clr_mask_r) |
        {ts_s, wd_fail, state_r == ST_STOP && wake_ev, tw_s};
    end
  end

  // wake pulse in stop mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulse_cnt_r <= 32'h0;
    end else if (state_r == ST_STOP && wake_ev) begin
      pulse_cnt_r <= 32'(`WAKE_PULSE_CYC);
    end else if (pulse_cnt_r != 32'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 32'h1;
    end
  end
  assign irq_lvl = (status_r & irq_en_r) != 4'h0;

  // pin outputs, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins.miso <= 1'b0;
      pins.rxd <= 1'b1;
      pins.reset_signal_n <= 1'b0;
      pins.irq_n <= 1'b1;
      pins.wd_fault_out_n <= 1'b1;
      bus_drive_dom <= 1'b0;
      vdd_reg_on <= 1'b1;
      can_mode <= 2'b00;
    end else begin
      pins.miso <= sel & tx_sh_r[7];
      pins.rxd <= ~bdom_s;
      pins.reset_signal_n <= !(state_r == ST_RESET || vlow_s || wd_fail);
      pins.irq_n <= !(irq_lvl || pulse_cnt_r != 32'h0);
      if (wd_fail) pins.wd_fault_out_n <= 1'b0;
      else if (wd_trig_r) pins.wd_fault_out_n <= 1'b1;
      bus_drive_dom <= (state_r == ST_NORMAL) && can_cfg_r == 2'(sbc_pkg::CAN_ACTIVE)
        && !txd_s;
      vdd_reg_on <= !ts_s && state_r != ST_SLEEP;
      can_mode <= can_cfg_r;
    end
  end
endmodule // sbc_device
`default_nettype wire

// ### verilog/sbc_host.sv
// microcontroller end: spi master from a command port, txd pass-through
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defines.svh"
module sbc_host (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins toward the basis chip
  sbc_if.host pins,
  // command port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // protocol controller side
  input wire logic tx_bit,
  output logic rx_bit,
  output logic chip_reset_n,
  output logic chip_irq_n,
  output logic chip_wd_fault_n
);
  logic miso_s, rxd_s, reset_signal_n_s, irqn_s, wdn_s;
  sync2 #(.W(5), .INIT(5'h0b)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({pins.miso, pins.rxd, pins.reset_signal_n, pins.irq_n, pins.wd_fault_out_n}),
    .q({miso_s, rxd_s, reset_signal_n_s, irqn_s, wdn_s})
  );
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;
  host_state_t st_r;
  logic [7:0] tx_r, rx_r, last_r;
  logic [3:0] edge_r;
  logic [15:0] div_r;
  logic [15:0] gap_r;
  logic done_r;
  logic start;
  assign start = wr && addr == `HA_CMD && st_r == H_IDLE;
  // shifter: host drives mosi, sclk idles low, samples miso on falling edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= H_IDLE;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      last_r <= 8'h00;
      edge_r <= 4'h0;
      div_r <= 16'h0;
      gap_r <= 16'h0;
      done_r <= 1'b0;
      pins.cs_n <= 1'b1;
      pins.sclk <= 1'b0;
      pins.mosi <= 1'b0;
    end else begin
      case (st_r)
        H_IDLE: if (start) begin
          st_r <= H_SHIFT;
          tx_r <= wdata[7:0];
          pins.cs_n <= 1'b0;
          pins.mosi <= wdata[7];
          edge_r <= 4'h0;
          div_r <= 16'h0;
          done_r <= 1'b0;
        end
        H_SHIFT: begin
          div_r <= div_r + 16'h1;
          if (div_r == 16'(`SCLK_HALF_CYC) - 16'h1) begin
            div_r <= 16'h0;
            pins.sclk <= ~pins.sclk;
            if (pins.sclk) begin
              // falling edge: take miso and count the bit
              rx_r <= {rx_r[6:0], miso_s};
              edge_r <= edge_r + 4'h1;
              if (edge_r == 4'h7) begin
                st_r <= H_GAP;
                gap_r <= 16'h0;
              end
            end else begin
              // rising edge: next bit out, a half period before the slave samples
              pins.mosi <= tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
        end
        H_GAP: begin
          // one guard spacing after every message keeps same-register gaps legal
          if (gap_r == 16'h2) begin
            pins.cs_n <= 1'b1;
            last_r <= rx_r;
            done_r <= 1'b1;
          end
          gap_r <= gap_r + 16'h1;
          if (gap_r >= 16'(`MSG_GAP_CYC)) st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
  // read port and pin relays
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0;
      pins.txd <= 1'b1;
      rx_bit <= 1'b1;
      chip_reset_n <= 1'b0;
      chip_irq_n <= 1'b1;
      chip_wd_fault_n <= 1'b1;
    end else begin
      rdata <= 32'h0;
      if (rd && addr == `HA_STATUS) rdata <= {30'h0, done_r, st_r != H_IDLE};
      else if (rd && addr == `HA_RXDATA) rdata <= {24'h0, last_r};
      pins.txd <= tx_bit;
      rx_bit <= rxd_s;
      chip_reset_n <= reset_signal_n_s;
      chip_irq_n <= irqn_s;
      chip_wd_fault_n <= wdn_s;
    end
  end
endmodule // sbc_host
`default_nettype wire

// ### verilog/sbc_if.sv
// pins between the basis chip and its microcontroller
`timescale 1ns/100ps
`default_nettype none
interface sbc_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic txd;
  logic rxd;
  logic reset_signal_n;
  logic irq_n;
  logic wd_fault_out_n;
  modport dev (
    input cs_n, sclk, mosi, txd,
    output miso, rxd, reset_signal_n, irq_n, wd_fault_out_n
  );
  modport host (
    output cs_n, sclk, mosi, txd,
    input miso, rxd, reset_signal_n, irq_n, wd_fault_out_n
  );
endinterface
`default_nettype wire

// ### verilog/sbc_pkg.sv
// types used by the basis chip core for its mode and can fields
package sbc_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_STOP,
    MODE_SLEEP
  } op_mode_t;
  typedef enum logic [1:0] {
    CAN_OFF,
    CAN_LISTEN,
    CAN_ACTIVE,
    CAN_RSVD
  } can_mode_t;
endpackage

// ### verilog/sync2.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // first stage is read only by the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync2
`default_nettype wire
